// [hdl/sls_pkg.sv]
// Shared constants and carrier types for the late-write SRAM port
package sls_pkg;
    localparam int LANE_W      = 9;
    localparam int LANE_DATA_W = 8;
    localparam int LANES       = 4;
    localparam int DATA_W      = LANES * LANE_W;
    localparam int ADDR_W      = 18;
    localparam int BURST_W     = 2;
    localparam int SYNC_W      = 2;
    localparam int IR_W        = 2;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 2'h1;

    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0,
        TAP_IDLE   = 4'h1,
        DR_SELECT  = 4'h2,
        DR_CAPTURE = 4'h3,
        DR_SHIFT   = 4'h4,
        DR_EXIT1   = 4'h5,
        DR_PAUSE   = 4'h6,
        DR_EXIT2   = 4'h7,
        DR_UPDATE  = 4'h8,
        IR_SELECT  = 4'h9,
        IR_CAPTURE = 4'hA,
        IR_SHIFT   = 4'hB,
        IR_EXIT1   = 4'hC,
        IR_PAUSE   = 4'hD,
        IR_EXIT2   = 4'hE,
        IR_UPDATE  = 4'hF
    } sls_tap_t;

    typedef struct packed {
        logic              valid;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_en;
    } sls_req_t;

    typedef struct packed {
        logic              tck;
        logic              tms;
        logic              tdi;
    } sls_jtag_t;

    typedef struct packed {
        logic [SYNC_W-1:0]  oe_n_sync;
        logic [SYNC_W-1:0]  sleep_sync;
        logic [SYNC_W-1:0]  order_sync;
        logic [SYNC_W-1:0]  ft_n_sync;
        logic [SYNC_W-1:0]  tck_sync;
        logic [SYNC_W-1:0]  tms_sync;
        logic [SYNC_W-1:0]  tdi_sync;
        logic               tck_prev;
        sls_req_t           s1;
        sls_req_t           s2;
        logic [ADDR_W-1:0]  burst_base;
        logic [BURST_W-1:0] burst_cnt;
        logic               burst_wr;
        logic               burst_live;
        logic               rd_valid;
        logic [DATA_W-1:0]  rd_data;
        logic               out_valid;
        logic [DATA_W-1:0]  dq_out;
        logic               dq_oe_n;
        logic               perr;
        logic               sleep_act;
        sls_tap_t           tap;
        logic [IR_W-1:0]    ir;
        logic               bypass;
        logic               tdo;
        logic               tdo_oe_n;
    } sls_state_t;

    localparam sls_state_t STATE_RST = '{dq_oe_n: 1'b1, tdo_oe_n: 1'b1, tap: TAP_RESET,
                                         default: '0};
endpackage

// [hdl/sls_sram_port.sv]
// Synchronous late-write SRAM port with burst, byte lanes, parity and test port
//
// Behaviour
// - Address, controls and write data are sampled on the rising clock edge.
// - Output enable released forces the data drivers off regardless of the pipeline.
// - A write starts at a clock edge and is self-timed; no write strobe.
// - Pipelined read data waits in an output register for the next edge.
// - Pipelined bursts deliver 3-1-1-1, flow-through bursts 2-1-1-1.
// - Write data follows its address by two cycles pipelined, one flow-through.
// - Reads and writes follow back to back with no idle cycles.
// - Per-lane write enables on 9-bit lanes; disabled lanes keep contents.
// - Burst order select picks linear or interleaved; board holds it fixed.
// - Three chip selects; a new access starts only when all are active, burst advance steps ignore them.
// - Sleep is asynchronous and forces the power-down state.
// - Parity is generated on writes, checked on reads, mismatches reported.
// - A standard boundary-scan test access port is provided.
// - Two selects active low, one active high; clock enable low-active freezes edges.
// - Burst advance high steps the burst counter, preset from two low address bits.
// - Mode select low is flow-through, high pipelined; write enables active low.
`timescale 1ns/1ps
module sls_sram_port #(
    parameter int AW = sls_pkg::ADDR_W
) (
    input  wire logic                      SYS_CLK,
    input  wire logic                      RST,
    input  wire logic [sls_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [sls_pkg::DATA_W-1:0] DQ_IN,
    output      logic [sls_pkg::DATA_W-1:0] DQ_OUT,
    output      logic                      DQ_OE_N,
    input  wire logic                      WRITE_EN_N,
    input  wire logic [sls_pkg::LANES-1:0] LANE_WRITE_EN_N,
    input  wire logic                      CHIP_SEL_A_N,
    input  wire logic                      CHIP_SEL_B,
    input  wire logic                      CHIP_SEL_C_N,
    input  wire logic                      CLK_EN_N,
    input  wire logic                      BURST_ADVANCE,
    input  wire logic                      BURST_ORDER_SEL,
    input  wire logic                      FLOW_THROUGH_SEL_N,
    input  wire logic                      OUT_EN_N,
    input  wire logic                      SLEEP_REQ,
    output      logic                      SLEEP_ACTIVE,
    output      logic                      PARITY_ERR_OUT,
    input  wire sls_pkg::sls_jtag_t        JTAG_IN,
    output      logic                      TDO,
    output      logic                      TDO_OE_N
);
    localparam int LW = sls_pkg::LANE_W;
    localparam int DW = sls_pkg::LANE_DATA_W;

    if (AW < sls_pkg::BURST_W + 1 || AW > sls_pkg::ADDR_W) begin : g_bad_aw
        $error("AW out of range for the address path");
    end

    sls_pkg::sls_state_t       q;
    sls_pkg::sls_state_t       n;
    logic [sls_pkg::DATA_W-1:0] mem [0:(2**AW)-1];

    logic                       ft;
    logic                       asleep;
    logic                       interleave;
    logic                       selected;
    logic                       step;
    logic                       tck_rise;
    sls_pkg::sls_req_t          commit;
    logic                       commit_wr;
    logic [sls_pkg::DATA_W-1:0] old_word;
    logic [sls_pkg::DATA_W-1:0] merged;
    logic [sls_pkg::DATA_W-1:0] fwd;
    logic                       wr_perr;
    logic [sls_pkg::BURST_W-1:0] cnt_nx;

    function automatic logic lanes_bad(input logic [sls_pkg::DATA_W-1:0] w,
                                       input logic [sls_pkg::LANES-1:0]  m);
        logic bad;
        bad = 1'b0;
        for (int l = 0; l < sls_pkg::LANES; l++) begin
            bad = bad | (m[l] & (^w[l*LW +: LW]));
        end
        return bad;
    endfunction

    function automatic logic [sls_pkg::ADDR_W-1:0] burst_addr(
        input logic [sls_pkg::ADDR_W-1:0]  base,
        input logic [sls_pkg::BURST_W-1:0] cnt,
        input logic                        ilv);
        logic [sls_pkg::BURST_W-1:0] low;
        low = ilv ? (base[sls_pkg::BURST_W-1:0] ^ cnt)
                  : (base[sls_pkg::BURST_W-1:0] + cnt);
        return {base[sls_pkg::ADDR_W-1:sls_pkg::BURST_W], low};
    endfunction

    assign ft         = ~q.ft_n_sync[1];
    assign asleep     = q.sleep_sync[1];
    assign interleave = q.order_sync[1];
    assign selected   = ~CHIP_SEL_A_N & CHIP_SEL_B & ~CHIP_SEL_C_N;
    assign step       = ~CLK_EN_N;
    assign tck_rise   = q.tck_sync[1] & ~q.tck_prev;
    assign cnt_nx     = q.burst_cnt + 2'h1;

    // Late write commits from the stage matching the mode's data delay
    assign commit    = ft ? q.s1 : q.s2;
    assign commit_wr = commit.valid & commit.wr & step;
    assign old_word  = mem[commit.addr[AW-1:0]];

    always_comb begin
        merged  = old_word;
        wr_perr = 1'b0;
        for (int l = 0; l < sls_pkg::LANES; l++) begin
            if (commit.lane_en[l]) begin
                merged[l*LW +: LW] = {^DQ_IN[l*LW +: DW], DQ_IN[l*LW +: DW]};
                wr_perr = wr_perr | (^DQ_IN[l*LW +: LW]);
            end
        end
        wr_perr = wr_perr & commit_wr;
    end

    // Read sees a write committing on the same edge to the same word
    always_comb begin
        fwd = mem[q.s1.addr[AW-1:0]];
        if (commit_wr && !ft && commit.addr[AW-1:0] == q.s1.addr[AW-1:0]) begin
            fwd = merged;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (commit_wr) begin
            mem[commit.addr[AW-1:0]] <= merged;
        end
    end

    always_comb begin
        n = q;
        n.oe_n_sync  = {q.oe_n_sync[0], OUT_EN_N};
        n.sleep_sync = {q.sleep_sync[0], SLEEP_REQ};
        n.order_sync = {q.order_sync[0], BURST_ORDER_SEL};
        n.ft_n_sync  = {q.ft_n_sync[0], FLOW_THROUGH_SEL_N};
        n.tck_sync   = {q.tck_sync[0], JTAG_IN.tck};
        n.tms_sync   = {q.tms_sync[0], JTAG_IN.tms};
        n.tdi_sync   = {q.tdi_sync[0], JTAG_IN.tdi};
        n.tck_prev   = q.tck_sync[1];
        n.sleep_act  = asleep;
        n.perr       = 1'b0;
        if (step) begin
            n.s2 = q.s1;
            if (asleep) begin
                n.s1         = '0;
                n.burst_live = 1'b0;
            end else if (BURST_ADVANCE && q.burst_live) begin
                n.burst_cnt = cnt_nx;
                n.s1 = '{valid: 1'b1, wr: q.burst_wr,
                         addr: burst_addr(q.burst_base, cnt_nx, interleave),
                         lane_en: q.burst_wr ? ~LANE_WRITE_EN_N : '0};
            end else if (!BURST_ADVANCE && selected) begin
                n.burst_base = ADDR;
                n.burst_cnt  = '0;
                n.burst_wr   = ~WRITE_EN_N;
                n.burst_live = 1'b1;
                n.s1 = '{valid: 1'b1, wr: ~WRITE_EN_N, addr: ADDR,
                         lane_en: WRITE_EN_N ? '0 : ~LANE_WRITE_EN_N};
            end else begin
                n.s1         = '0;
                n.burst_live = 1'b0;
            end
            n.rd_valid = q.s1.valid & ~q.s1.wr;
            n.rd_data  = fwd;
            if (ft) begin
                n.out_valid = q.s1.valid & ~q.s1.wr;
                n.dq_out    = fwd;
            end else begin
                n.out_valid = q.rd_valid;
                n.dq_out    = q.rd_data;
            end
            n.perr = wr_perr | (n.out_valid & lanes_bad(n.dq_out, '1));
        end
        if (asleep) begin
            n.out_valid = 1'b0;
        end
        n.dq_oe_n = ~(n.out_valid & ~q.oe_n_sync[1]);

        // Test access port, bypass register only
        if (tck_rise) begin
            unique case (q.tap)
                sls_pkg::TAP_RESET:  n.tap = q.tms_sync[1] ? sls_pkg::TAP_RESET
                                                            : sls_pkg::TAP_IDLE;
                sls_pkg::TAP_IDLE:   n.tap = q.tms_sync[1] ? sls_pkg::DR_SELECT
                                                            : sls_pkg::TAP_IDLE;
                sls_pkg::DR_SELECT:  n.tap = q.tms_sync[1] ? sls_pkg::IR_SELECT
                                                            : sls_pkg::DR_CAPTURE;
                sls_pkg::DR_CAPTURE: n.tap = q.tms_sync[1] ? sls_pkg::DR_EXIT1
                                                            : sls_pkg::DR_SHIFT;
                sls_pkg::DR_SHIFT:   n.tap = q.tms_sync[1] ? sls_pkg::DR_EXIT1
                                                            : sls_pkg::DR_SHIFT;
                sls_pkg::DR_EXIT1:   n.tap = q.tms_sync[1] ? sls_pkg::DR_UPDATE
                                                            : sls_pkg::DR_PAUSE;
                sls_pkg::DR_PAUSE:   n.tap = q.tms_sync[1] ? sls_pkg::DR_EXIT2
                                                            : sls_pkg::DR_PAUSE;
                sls_pkg::DR_EXIT2:   n.tap = q.tms_sync[1] ? sls_pkg::DR_UPDATE
                                                            : sls_pkg::DR_SHIFT;
                sls_pkg::DR_UPDATE:  n.tap = q.tms_sync[1] ? sls_pkg::DR_SELECT
                                                            : sls_pkg::TAP_IDLE;
                sls_pkg::IR_SELECT:  n.tap = q.tms_sync[1] ? sls_pkg::TAP_RESET
                                                            : sls_pkg::IR_CAPTURE;
                sls_pkg::IR_CAPTURE: n.tap = q.tms_sync[1] ? sls_pkg::IR_EXIT1
                                                            : sls_pkg::IR_SHIFT;
                sls_pkg::IR_SHIFT:   n.tap = q.tms_sync[1] ? sls_pkg::IR_EXIT1
                                                            : sls_pkg::IR_SHIFT;
                sls_pkg::IR_EXIT1:   n.tap = q.tms_sync[1] ? sls_pkg::IR_UPDATE
                                                            : sls_pkg::IR_PAUSE;
                sls_pkg::IR_PAUSE:   n.tap = q.tms_sync[1] ? sls_pkg::IR_EXIT2
                                                            : sls_pkg::IR_PAUSE;
                sls_pkg::IR_EXIT2:   n.tap = q.tms_sync[1] ? sls_pkg::IR_UPDATE
                                                            : sls_pkg::IR_SHIFT;
                sls_pkg::IR_UPDATE:  n.tap = q.tms_sync[1] ? sls_pkg::DR_SELECT
                                                            : sls_pkg::TAP_IDLE;
            endcase
            unique case (q.tap)
                sls_pkg::DR_CAPTURE: n.bypass = 1'b0;
                sls_pkg::DR_SHIFT: begin
                    n.tdo    = q.bypass;
                    n.bypass = q.tdi_sync[1];
                end
                sls_pkg::IR_CAPTURE: n.ir = sls_pkg::IR_CAPTURE_VAL;
                sls_pkg::IR_SHIFT: begin
                    n.tdo = q.ir[0];
                    n.ir  = {q.tdi_sync[1], q.ir[sls_pkg::IR_W-1:1]};
                end
                default: n.tdo = q.tdo;
            endcase
            n.tdo_oe_n = ~(q.tap == sls_pkg::DR_SHIFT || q.tap == sls_pkg::IR_SHIFT);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            q <= sls_pkg::STATE_RST;
        end else begin
            q <= n;
        end
    end

    assign DQ_OUT         = q.dq_out;
    assign DQ_OE_N        = q.dq_oe_n;
    assign SLEEP_ACTIVE   = q.sleep_act;
    assign PARITY_ERR_OUT = q.perr;
    assign TDO            = q.tdo;
    assign TDO_OE_N       = q.tdo_oe_n;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    logic new_req;
    logic new_rd;
    logic new_wr;
    assign new_req = step & ~asleep & ~BURST_ADVANCE & selected;
    assign new_rd  = new_req & WRITE_EN_N;
    assign new_wr  = new_req & ~WRITE_EN_N;

    sequence s_ft_read;
        ft && new_rd ##1 step;
    endsequence
    sequence s_pl_read;
        !ft && new_rd ##1 step ##1 step;
    endsequence
    sequence s_pl_write;
        !ft && new_wr ##1 step && !ft ##1 step && !ft;
    endsequence

    property p_ft_lat;
        s_ft_read |=> q.out_valid && q.dq_out == $past(fwd);
    endproperty
    a_ft_lat: assert property (p_ft_lat) else $error("flow-through read latency wrong");

    property p_pl_lat;
        s_pl_read |=> q.out_valid && q.dq_out == $past(q.rd_data);
    endproperty
    a_pl_lat: assert property (p_pl_lat) else $error("pipelined read latency wrong");

    property p_pl_write;
        s_pl_write |-> commit_wr && commit.addr == $past(ADDR, 2);
    endproperty
    a_pl_write: assert property (p_pl_write) else $error("late write not committed");

    property p_oe_off;
        q.oe_n_sync[1] |=> q.dq_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drivers on with output disabled");

    property p_sleep;
        asleep |=> !q.s1.valid && q.sleep_act && q.dq_oe_n;
    endproperty
    a_sleep: assert property (p_sleep) else $error("activity while asleep");

    property p_desel;
        step && !asleep && !BURST_ADVANCE && !selected |=> !q.s1.valid;
    endproperty
    a_desel: assert property (p_desel) else $error("access without all selects");

    property p_lane_keep;
        logic [AW-1:0] a;
        logic [sls_pkg::DATA_W-1:0] w;
        (commit_wr, a = commit.addr[AW-1:0], w = merged) |=> mem[a] == w;
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("byte lane write wrong");

    property p_burst;
        step && !asleep && BURST_ADVANCE && q.burst_live |=>
            q.s1.valid && q.s1.addr == burst_addr($past(q.burst_base), $past(cnt_nx),
                                                  $past(interleave));
    endproperty
    a_burst: assert property (p_burst) else $error("burst address order wrong");

    property p_b2b;
        new_req ##1 new_req |=> q.s1.valid && q.s2.valid;
    endproperty
    a_b2b: assert property (p_b2b) else $error("back to back access dropped");

    property p_idle_off;
        step && !q.s1.valid && !q.rd_valid |=> q.dq_oe_n;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("outputs driven when idle");

    property p_wr_parity;
        wr_perr |=> q.perr;
    endproperty
    a_wr_parity: assert property (p_wr_parity) else $error("parity error not flagged");

    property p_tap_bypass;
        tck_rise && q.tap == sls_pkg::DR_SHIFT |=> q.tdo == $past(q.bypass) && !q.tdo_oe_n;
    endproperty
    a_tap_bypass: assert property (p_tap_bypass) else $error("bypass shift wrong");
endmodule

// [sim/sls_host_model.sv]
// Host memory controller model driving the late-write SRAM bus
`timescale 1ns/1ps
module sls_host_model (
    output logic [17:0] addr,
    output logic [35:0] dq,
    output logic        we_n,
    output logic [3:0]  lane_n,
    output logic        cs_a_n,
    output logic        cs_b,
    output logic        cs_c_n,
    output logic        ce_n,
    output logic        burst_advance,
    output logic        order,
    output logic        ft_n,
    output logic        oe_n,
    output logic        sleep
);
    bit          cfg_ft = 1'b1;
    bit          cfg_ord;
    bit          cfg_oe;
    bit          cfg_sl;
    logic [35:0] sched [0:1];

    initial begin
        {addr, dq, we_n, lane_n, ce_n, burst_advance} = '0;
        {cs_a_n, cs_b, cs_c_n} = 3'h5;
        {order, ft_n, oe_n, sleep} = 4'h4;
        sched = '{36'h5_A5A5_A5A5, 36'h0_5A5A_5A5A};
    end

    // Called just after a rising edge; idle data slots carry the inverse of the last value
    task automatic drive(input bit rd, wr, ad, st, input logic [2:0] dsel,
                         input logic [17:0] a, input logic [3:0] ln, input logic [35:0] d);
        logic [35:0] junk;
        junk = ~dq;
        order  <= cfg_ord;
        ft_n   <= cfg_ft;
        oe_n   <= cfg_oe;
        sleep  <= cfg_sl;
        ce_n   <= st;
        burst_advance    <= ad;
        we_n   <= ~wr;
        lane_n <= ~ln;
        addr   <= a;
        {cs_a_n, cs_b, cs_c_n} <= 3'h2 ^ dsel;
        dq     <= sched[0];
        if (!st) begin
            sched[0] = sched[1];
            sched[1] = junk;
            if (wr) sched[cfg_ft] = d;
        end
    endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the late-write SRAM port
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk;
    logic        rst;
    logic [17:0] addr;
    logic [35:0] dq_in;
    logic [35:0] dq_out;
    logic        dq_oe_n;
    logic        we_n;
    logic [3:0]  lane_n;
    logic        cs_a_n;
    logic        cs_b;
    logic        cs_c_n;
    logic        ce_n;
    logic        burst_advance;
    logic        order;
    logic        ft_n;
    logic        oe_n;
    logic        sleep;
    logic        sleep_act;
    logic        perr;
    logic        tdo_oe_n;
    logic [35:0] mem [0:63];
    logic [37:0] ex [0:2];
    logic [31:0] seed = 32'h0000_0014;
    int          errors;
    int          checks;
    bit          pst;
    bit          oe_off;
    bit          asleep;
    bit          rst_v;
    logic [2:0]  jtag = 3'h0;
    logic        tdo;
    logic [31:0] tap_r;

    sls_sram_port #(.AW(6)) DUT (
        .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
        .DQ_OE_N(dq_oe_n), .WRITE_EN_N(we_n), .LANE_WRITE_EN_N(lane_n),
        .CHIP_SEL_A_N(cs_a_n), .CHIP_SEL_B(cs_b), .CHIP_SEL_C_N(cs_c_n), .CLK_EN_N(ce_n),
        .BURST_ADVANCE(burst_advance), .BURST_ORDER_SEL(order), .FLOW_THROUGH_SEL_N(ft_n),
        .OUT_EN_N(oe_n), .SLEEP_REQ(sleep), .SLEEP_ACTIVE(sleep_act), .PARITY_ERR_OUT(perr),
        .JTAG_IN(jtag), .TDO(tdo), .TDO_OE_N(tdo_oe_n));

    sls_host_model host (
        .addr(addr), .dq(dq_in), .we_n(we_n), .lane_n(lane_n), .cs_a_n(cs_a_n), .cs_b(cs_b),
        .cs_c_n(cs_c_n), .ce_n(ce_n), .burst_advance(burst_advance), .order(order), .ft_n(ft_n), .oe_n(oe_n),
        .sleep(sleep));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Stored lane bit 8 is the even parity of the lane's data byte
    function automatic logic [35:0] par(input logic [35:0] d);
        for (int l = 0; l < 4; l++) d[l*9+8] = ^d[l*9+:8];
        return d;
    endfunction

    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One bus cycle; expectations advance only on edges with clock enable low
    task automatic beat(input bit rd, wr, ad, st, input logic [2:0] dsel,
                        input logic [5:0] a, input logic [3:0] ln, input logic [35:0] d);
        int          lat;
        logic [31:0] r;
        lat = host.cfg_ft ? 2 : 1;
        r = rnd();
        @(posedge sys_clk);
        rst <= rst_v;
        host.drive(rd, wr, ad, st, dsel, (ad | st) ? r[17:0] : {12'h000, a}, ln, d);
        #1;
        if (!pst) begin
            if (ex[0][37] && !oe_off) cmp(dq_out, ex[0][35:0]);
            if (ex[0][37]) cmp({35'h0, dq_oe_n}, {35'h0, oe_off});
            cmp({35'h0, perr}, {35'h0, ex[0][36]});
            ex[0] = ex[1];
            ex[1] = ex[2];
            ex[2] = '0;
        end
        pst = st;
        if (!st && !asleep && !rst_v && dsel == 3'h0) begin
            if (rd) ex[lat] = {2'h2, par(mem[a])};
            if (wr) begin
                ex[lat][36] = |(ln & {^d[35:27], ^d[26:18], ^d[17:9], ^d[8:0]});
                for (int l = 0; l < 4; l++) if (ln[l]) mem[a][l*9+:9] = d[l*9+:9];
            end
        end
    endtask

    task automatic idle(input int n);
        repeat (n) beat(0, 0, 0, 0, 3'h1, 6'h00, 4'h0, 36'h0);
    endtask

    // One slow test clock period, four system clocks low then five high
    task automatic tap_bit(input bit tms, input bit tdi, input bit chk, input bit exp);
        @(posedge sys_clk);
        jtag <= {1'b0, tms, tdi};
        repeat (4) @(posedge sys_clk);
        jtag <= {1'b1, tms, tdi};
        repeat (4) @(posedge sys_clk);
        #1;
        if (chk) cmp({34'h0, tdo_oe_n, tdo}, {35'h0, exp});
    endtask

    task automatic burst(input bit wr, input logic [5:0] a);
        logic [31:0] r;
        for (int c = 0; c < 4; c++) begin
            r = rnd();
            beat(!wr, wr, c != 0, 0, 3'h0,
                 {a[5:2], host.cfg_ord ? a[1:0] ^ 2'(c) : a[1:0] + 2'(c)}, r[3:0],
                 par({r[7:4], rnd()}));
        end
    endtask

    // Random mix of deselects, stalls, reads and writes, often on few words
    task automatic run(input int n);
        logic [31:0] r;
        logic [35:0] d;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            d = par({r[3:0], rnd()});
            if (r[15:13] == 3'h7) d[8] = ~d[8];
            case (r[2:0])
                3'h0: beat(0, r[11], 0, 0, r[4] ? 3'h4 : (r[3] ? 3'h2 : 3'h1), r[10:5], 4'hF, d);
                3'h1: beat(1, 0, 0, 1, 3'h0, 6'h00, 4'h0, d);
                3'h2, 3'h3: beat(1, 0, 0, 0, 3'h0, r[21:16] & (r[31] ? 6'h03 : 6'h3F), 4'h0, d);
                default: beat(0, 1, 0, 0, 3'h0, r[21:16] & (r[31] ? 6'h03 : 6'h3F), r[25:22], d);
            endcase
        end
    endtask

    task automatic phase(input bit f, input bit o);
        host.cfg_ft = f;
        host.cfg_ord = o;
        rst_v = 1'b1;
        ex = '{default: '0};
        pst = 1'b0;
        idle(5);
        rst_v = 1'b0;
        idle(4);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        errors++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        for (int p = 0; p < 4; p++) begin
            phase(p[0], p[1]);
            if (p == 0) for (int a = 0; a < 64; a++) beat(0, 1, 0, 0, 3'h0, 6'(a), 4'hF, par(36'(a)));
            burst(1, 6'h0D);
            burst(0, 6'h0D);
            burst(0, 6'h32);
            run(300);
            idle(4);
            cmp({35'h0, dq_oe_n}, 36'h0_0000_0001);
        end
        host.cfg_oe = 1'b1;
        idle(4);
        oe_off = 1'b1;
        run(40);
        host.cfg_oe = 1'b0;
        idle(4);
        oe_off = 1'b0;
        host.cfg_sl = 1'b1;
        idle(6);
        cmp({35'h0, sleep_act}, 36'h0_0000_0001);
        asleep = 1'b1;
        beat(0, 1, 0, 0, 3'h0, 6'h05, 4'hF, 36'h0_0000_0000);
        host.cfg_sl = 1'b0;
        idle(6);
        asleep = 1'b0;
        cmp({35'h0, sleep_act}, 36'h0_0000_0000);
        beat(1, 0, 0, 0, 3'h0, 6'h05, 4'h0, 36'h0_0000_0000);
        idle(4);
        // Test port: idle, into data shift, eight bypass bits, out to idle
        tap_r = rnd() << 1;
        tap_bit(0, 0, 0, 0);
        tap_bit(1, 0, 0, 0);
        tap_bit(0, 0, 0, 0);
        tap_bit(0, 0, 0, 0);
        for (int i = 0; i < 8; i++) tap_bit(i == 7, tap_r[i+1], 1, tap_r[i]);
        tap_bit(1, 0, 0, 0);
        tap_bit(0, 0, 0, 0);
        cmp({35'h0, tdo_oe_n}, 36'h0_0000_0001);
        wrap_up();
    end
endmodule
